//--- hdl/cic_charger_input_config_regs.sv
// Three charger input configuration registers behind a serial slave.
// Assumes scl and sda levels arrive synchronous to clk_sys and are sampled
// slowly enough that every line change lasts several clock cycles.
//
// Operation
// - Bit 7 of the first register enables input high impedance; resets zero.
// - Bit 6 of the first register enables the current limit pin; resets one.
// - Six-bit cap code is 100 mA plus 50 mA per count; default 500 mA.
// - Effective current cap is the lower of register code and pin limit.
// - Finished source detection rewrites the cap code by detected source type.
// - Boost hot selector: 00, 01, 10 pick thresholds; 11 disables protection.
// - Boost cold selector bit: zero 77 percent default, one 80 percent.
// - Five-bit voltage floor offset weighs 100 mV per count; default 600 mV.
// - The computed voltage floor is clamped between 3.9 V and 15.3 V.
// - Above 6 V unloaded input the offset is doubled before use.
// - Watchdog expiry reloads all fields except cap, floor offset and the third register.
// - Reads above register 0x14 return 0xFF.
`timescale 1ns/100ps
module cic_charger_input_config_regs (
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  input  wire logic                 sclIn,
  input  wire logic                 sdaIn,
  output logic                      sdaOut,
  output logic                      sdaOe,
  input  wire logic                 softRegReset,
  input  wire logic                 watchdogExpire,
  input  wire logic                 detectDone,
  input  wire logic [3:0]           sourceType,
  input  wire logic [5:0]           currentLimitPinCode,
  input  wire logic [15:0]          supplyNoLoadMv,
  output logic                      inputHighzEnable,
  output logic                      currentPinLimitEnable,
  output logic [5:0]                effectiveCurrentCap,
  output logic [1:0]                boostHotThresholdSel,
  output logic                      boostHotProtEnable,
  output logic                      boostColdThresholdSel,
  output logic [15:0]               inputVoltageFloor,
  output logic [7:0]                conversionDetectControl
);
  import cic_pkg::*;

  typedef struct packed {
    cic_state_t  state;
    logic        sclPrev;
    logic        sdaPrev;
    logic [3:0]  bitCnt;
    logic [7:0]  shift;
    logic [7:0]  ptr;
    logic        isRead;
    logic        ackOk;
    logic        sdaOe;
    logic        hotProtEn;
    logic [7:0]  reg0;
    logic [7:0]  reg1;
    logic [7:0]  reg2;
    logic [5:0]  capEff;
    logic [15:0] floorMv;
  } cic_regs_t;

  cic_regs_t r;
  cic_regs_t next_r;

  // Cap code chosen for each detected source; unlisted types act as unknown.
  function automatic logic [5:0] capForSource(input logic [3:0] t);
    case (t)
      CIC_SRC_SDP:   capForSource = CIC_CAP_500MA;
      CIC_SRC_CDP:   capForSource = CIC_CAP_1500MA;
      CIC_SRC_DCP:   capForSource = CIC_CAP_3250MA;
      CIC_SRC_HVDCP: capForSource = CIC_CAP_1500MA;
      CIC_SRC_NS1A:  capForSource = CIC_CAP_1000MA;
      CIC_SRC_NS2A:  capForSource = CIC_CAP_2000MA;
      CIC_SRC_NS2A1: capForSource = CIC_CAP_2100MA;
      CIC_SRC_NS2A4: capForSource = CIC_CAP_2400MA;
      default:       capForSource = CIC_CAP_500MA;
    endcase
  endfunction : capForSource

  // Read data for one register pointer.
  function automatic logic [7:0] readReg(input logic [7:0] p,
                                         input cic_regs_t s);
    if (p == CIC_OFS_INPUT_CURRENT_CONTROL) begin
      readReg = s.reg0;
    end else if (p == CIC_OFS_BOOST_THERMAL_VIN_OFFSET) begin
      readReg = s.reg1;
    end else if (p == CIC_OFS_CONVERSION_DETECT_CONTROL) begin
      readReg = s.reg2;
    end else if (p > CIC_OFS_LAST) begin
      readReg = CIC_READ_BEYOND;
    end else begin
      readReg = CIC_READ_UNMAPPED;
    end
  endfunction : readReg

  // Serial slave, register updates and derived outputs in one pass.
  always_comb begin
    logic        sclRise, sclFall, startSeen, stopSeen, hostWrite;
    logic [7:0]  wrData, rdByte;
    logic [16:0] offMv, input_supply_voltage, flr;
    sclRise   = sclIn && !r.sclPrev;
    sclFall   = !sclIn && r.sclPrev;
    startSeen = sclIn && r.sclPrev && r.sdaPrev && !sdaIn;
    stopSeen  = sclIn && r.sclPrev && !r.sdaPrev && sdaIn;
    hostWrite = 1'b0;
    wrData    = 8'h00;
    rdByte    = 8'h00;
    offMv     = 17'd0;
    input_supply_voltage      = 17'd0;
    flr       = 17'd0;
    next_r    = r;
    next_r.sclPrev = sclIn;
    next_r.sdaPrev = sdaIn;

    // Bits are shifted in on the rising clock edge, MSB first.
    if (sclRise && (r.state == CIC_ADDR || r.state == CIC_REGPTR ||
                    r.state == CIC_WRDATA)) begin
      next_r.shift  = {r.shift[6:0], sdaIn};
      next_r.bitCnt = r.bitCnt + 4'd1;
    end

    case (r.state)
      CIC_ADDR: begin
        if (sclFall && r.bitCnt == 4'd8) begin
          if (r.shift[7:1] == CIC_SLAVE_ADDR) begin
            next_r.isRead = r.shift[0];
            next_r.sdaOe  = 1'b1;
            next_r.state  = CIC_ACK_ADR;
          end else begin
            next_r.state = CIC_IDLE;
          end
        end
      end
      CIC_ACK_ADR: begin
        if (sclFall) begin
          next_r.bitCnt = 4'd0;
          if (r.isRead) begin
            rdByte        = readReg(r.ptr, r);
            next_r.shift  = rdByte;
            next_r.sdaOe  = !rdByte[7];
            next_r.state  = CIC_RDDATA;
          end else begin
            next_r.sdaOe = 1'b0;
            next_r.state = CIC_REGPTR;
          end
        end
      end
      CIC_REGPTR: begin
        if (sclFall && r.bitCnt == 4'd8) begin
          next_r.ptr   = r.shift;
          next_r.sdaOe = 1'b1;
          next_r.state = CIC_ACK_WR;
        end
      end
      CIC_ACK_WR: begin
        if (sclFall) begin
          next_r.sdaOe  = 1'b0;
          next_r.bitCnt = 4'd0;
          next_r.state  = CIC_WRDATA;
        end
      end
      CIC_WRDATA: begin
        if (sclFall && r.bitCnt == 4'd8) begin
          hostWrite    = 1'b1;
          wrData       = r.shift;
          next_r.ptr   = r.ptr + 8'd1;
          next_r.sdaOe = 1'b1;
          next_r.state = CIC_ACK_WR;
        end
      end
      CIC_RDDATA: begin
        // Data bits are driven after each falling edge, counted on rises.
        if (sclRise) begin
          next_r.bitCnt = r.bitCnt + 4'd1;
        end
        if (sclFall && r.bitCnt == 4'd8) begin
          next_r.sdaOe = 1'b0;
          next_r.state = CIC_RDACK;
        end else if (sclFall) begin
          next_r.shift = {r.shift[6:0], 1'b0};
          next_r.sdaOe = !r.shift[6];
        end
      end
      CIC_RDACK: begin
        if (sclRise) begin
          next_r.ackOk = !sdaIn;
        end
        if (sclFall) begin
          if (r.ackOk) begin
            rdByte        = readReg(r.ptr + 8'd1, r);
            next_r.ptr    = r.ptr + 8'd1;
            next_r.shift  = rdByte;
            next_r.sdaOe  = !rdByte[7];
            next_r.bitCnt = 4'd0;
            next_r.state  = CIC_RDDATA;
          end else begin
            next_r.state = CIC_IDLE;
          end
        end
      end
      default: begin
        next_r.state = CIC_IDLE;
      end
    endcase

    // A start restarts address reception; a stop frees the bus.
    if (startSeen) begin
      next_r.state  = CIC_ADDR;
      next_r.bitCnt = 4'd0;
      next_r.sdaOe  = 1'b0;
    end else if (stopSeen) begin
      next_r.state = CIC_IDLE;
      next_r.sdaOe = 1'b0;
    end

    // Host writes store whole bytes; every field reads back as stored.
    if (hostWrite) begin
      if (r.ptr == CIC_OFS_INPUT_CURRENT_CONTROL) begin
        next_r.reg0 = wrData;
      end else if (r.ptr == CIC_OFS_BOOST_THERMAL_VIN_OFFSET) begin
        next_r.reg1 = wrData;
      end else if (r.ptr == CIC_OFS_CONVERSION_DETECT_CONTROL) begin
        next_r.reg2 = wrData;
      end
    end

    // Detection beats a host write to the cap in the same cycle.
    if (detectDone) begin
      next_r.reg0[CIC_CAP_MSB:0] = capForSource(sourceType);
    end

    // Watchdog keeps the cap, floor offset and third register, reloading the rest.
    if (watchdogExpire) begin
      next_r.reg0[CIC_BIT_HIGHZ:CIC_BIT_PIN_EN] =
        CIC_RST_INPUT_CURRENT_CONTROL[CIC_BIT_HIGHZ:CIC_BIT_PIN_EN];
      next_r.reg1[CIC_HOT_MSB:CIC_BIT_COLD] =
        CIC_RST_BOOST_THERMAL_VIN_OFFSET[CIC_HOT_MSB:CIC_BIT_COLD];
    end

    // Software register reset reloads every field.
    if (softRegReset) begin
      next_r.reg0 = CIC_RST_INPUT_CURRENT_CONTROL;
      next_r.reg1 = CIC_RST_BOOST_THERMAL_VIN_OFFSET;
      next_r.reg2 = CIC_RST_CONVERSION_DETECT_CONTROL;
    end

    // The lower of pin and register limits governs, from current fields.
    if (r.reg0[CIC_BIT_PIN_EN] && currentLimitPinCode < r.reg0[5:0]) begin
      next_r.capEff = currentLimitPinCode;
    end else begin
      next_r.capEff = r.reg0[CIC_CAP_MSB:0];
    end

    // Floor is unloaded input minus offset; an underflow clamps low.
    offMv = 17'(r.reg1[CIC_OFS_MSB:0]) * CIC_OFS_STEP_MV;
    input_supply_voltage  = {1'b0, supplyNoLoadMv};
    if (input_supply_voltage > CIC_DOUBLE_ABOVE) begin
      offMv = {offMv[15:0], 1'b0};
    end
    flr = (input_supply_voltage > offMv) ? input_supply_voltage - offMv : 17'd0;
    if (flr < CIC_FLOOR_MIN_MV) begin
      flr = CIC_FLOOR_MIN_MV;
    end else if (flr > CIC_FLOOR_MAX_MV) begin
      flr = CIC_FLOOR_MAX_MV;
    end
    next_r.floorMv = flr[15:0];
    if (srst) begin
      next_r         = '0;
      next_r.state   = CIC_IDLE;
      next_r.sclPrev = 1'b1;
      next_r.sdaPrev = 1'b1;
      next_r.reg0    = CIC_RST_INPUT_CURRENT_CONTROL;
      next_r.reg1    = CIC_RST_BOOST_THERMAL_VIN_OFFSET;
      next_r.reg2    = CIC_RST_CONVERSION_DETECT_CONTROL;
      next_r.capEff  = CIC_CAP_500MA;
      next_r.floorMv = CIC_FLOOR_MIN_MV[15:0];
    end
    // Kept as a flop beside its selector so the output carries no gates.
    next_r.hotProtEn =
      (next_r.reg1[CIC_HOT_MSB:CIC_HOT_LSB] != CIC_HOT_DISABLE);
  end

  // Single state register; reset is folded into the next-state logic.
  always_ff @(posedge clk_sys) begin
    r <= next_r;
  end

  // Outputs are register fields; the data pin only ever pulls low.
  assign sdaOut                  = 1'b0;
  assign sdaOe                   = r.sdaOe;
  assign inputHighzEnable        = r.reg0[CIC_BIT_HIGHZ];
  assign currentPinLimitEnable   = r.reg0[CIC_BIT_PIN_EN];
  assign effectiveCurrentCap     = r.capEff;
  assign boostHotThresholdSel    = r.reg1[CIC_HOT_MSB:CIC_HOT_LSB];
  assign boostHotProtEnable      = r.hotProtEn;
  assign boostColdThresholdSel   = r.reg1[CIC_BIT_COLD];
  assign inputVoltageFloor       = r.floorMv;
  assign conversionDetectControl = r.reg2;

endmodule : cic_charger_input_config_regs

//--- hdl/cic_pkg.sv
// Constants for the charger input configuration register bank.
// Assumes a byte-wide register space reached over a two-wire serial link.
package cic_pkg;

  // Serial slave address, seven bits.
  localparam logic [6:0] CIC_SLAVE_ADDR = 7'h6A;

  // Register offsets and the top of the decoded register space.
  localparam logic [7:0] CIC_OFS_INPUT_CURRENT_CONTROL     = 8'h00;
  localparam logic [7:0] CIC_OFS_BOOST_THERMAL_VIN_OFFSET  = 8'h01;
  localparam logic [7:0] CIC_OFS_CONVERSION_DETECT_CONTROL = 8'h02;
  localparam logic [7:0] CIC_OFS_LAST                      = 8'h14;
  localparam logic [7:0] CIC_READ_BEYOND                   = 8'hFF;
  localparam logic [7:0] CIC_READ_UNMAPPED                 = 8'h00;

  // Reset values.
  localparam logic [7:0] CIC_RST_INPUT_CURRENT_CONTROL     = 8'h48;
  localparam logic [7:0] CIC_RST_BOOST_THERMAL_VIN_OFFSET  = 8'h06;
  localparam logic [7:0] CIC_RST_CONVERSION_DETECT_CONTROL = 8'h11;

  // Field positions.
  localparam int CIC_BIT_HIGHZ      = 7;
  localparam int CIC_BIT_PIN_EN     = 6;
  localparam int CIC_CAP_MSB        = 5;
  localparam int CIC_HOT_MSB        = 7;
  localparam int CIC_HOT_LSB        = 6;
  localparam int CIC_BIT_COLD       = 5;
  localparam int CIC_OFS_MSB        = 4;

  // Hot threshold code that turns boost thermal protection off.
  localparam logic [1:0] CIC_HOT_DISABLE = 2'b11;

  // Input current cap codes: 100 mA plus 50 mA per count.
  localparam logic [5:0] CIC_CAP_500MA  = 6'h08;
  localparam logic [5:0] CIC_CAP_1000MA = 6'h12;
  localparam logic [5:0] CIC_CAP_1500MA = 6'h1C;
  localparam logic [5:0] CIC_CAP_2000MA = 6'h26;
  localparam logic [5:0] CIC_CAP_2100MA = 6'h28;
  localparam logic [5:0] CIC_CAP_2400MA = 6'h2E;
  localparam logic [5:0] CIC_CAP_3250MA = 6'h3F;

  // Detected input source types.
  localparam logic [3:0] CIC_SRC_SDP    = 4'h0;
  localparam logic [3:0] CIC_SRC_CDP    = 4'h1;
  localparam logic [3:0] CIC_SRC_DCP    = 4'h2;
  localparam logic [3:0] CIC_SRC_HVDCP  = 4'h3;
  localparam logic [3:0] CIC_SRC_UNKN   = 4'h4;
  localparam logic [3:0] CIC_SRC_NS1A   = 4'h5;
  localparam logic [3:0] CIC_SRC_NS2A   = 4'h6;
  localparam logic [3:0] CIC_SRC_NS2A1  = 4'h7;
  localparam logic [3:0] CIC_SRC_NS2A4  = 4'h8;

  // Input voltage floor arithmetic, all in millivolts.
  localparam logic [16:0] CIC_OFS_STEP_MV  = 17'd100;
  localparam logic [16:0] CIC_DOUBLE_ABOVE = 17'd6000;
  localparam logic [16:0] CIC_FLOOR_MIN_MV = 17'd3900;
  localparam logic [16:0] CIC_FLOOR_MAX_MV = 17'd15300;

  // Serial slave states, one-hot.
  typedef enum logic [8:0] {
    CIC_IDLE    = 9'b0_0000_0001,
    CIC_ADDR    = 9'b0_0000_0010,
    CIC_ACK_ADR = 9'b0_0000_0100,
    CIC_REGPTR  = 9'b0_0000_1000,
    CIC_ACK_WR  = 9'b0_0001_0000,
    CIC_WRDATA  = 9'b0_0010_0000,
    CIC_RDDATA  = 9'b0_0100_0000,
    CIC_RDACK   = 9'b0_1000_0000,
    CIC_SPARE   = 9'b1_0000_0000
  } cic_state_t;

endpackage : cic_pkg

//--- tb/cic_charger_input_config_regs_bench.sv
// Self-checking bench for the charger input configuration registers.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/100ps
module cic_charger_input_config_regs_bench;
  import cic_pkg::*;
  logic clk_sys = 1'b0, srst = 1'b1, sclIn, sdaIn, sdaOut, sdaOe;
  logic softRegReset = 1'b0, watchdogExpire = 1'b0, detectDone = 1'b0;
  logic [3:0] sourceType = 4'h0;
  logic [5:0] currentLimitPinCode = 6'h10, effectiveCurrentCap;
  logic [15:0] supplyNoLoadMv = 16'h1388, inputVoltageFloor;
  logic inputHighzEnable, currentPinLimitEnable, boostHotProtEnable;
  logic [1:0] boostHotThresholdSel;
  logic boostColdThresholdSel;
  logic [7:0] conversionDetectControl, q;
  int mismatches = 0, samples_checked = 0, cycles = 0, e;
  logic [7:0] rstTab [3] = '{8'h48, 8'h06, 8'h11};
  logic [5:0] capTab [10] = '{6'h08, 6'h1C, 6'h3F, 6'h1C, 6'h08, 6'h12,
                              6'h26, 6'h28, 6'h2E, 6'h08};
  int ofsTab [7] = '{6, 6, 6, 6, 6, 0, 31};
  int supTab [7] = '{5000, 6000, 6100, 12000, 4000, 16000, 9000};

  always #20 clk_sys = ~clk_sys;
  cic_host_model host (.clk_sys(clk_sys), .sdaOe(sdaOe), .sclIn(sclIn),
                       .sdaIn(sdaIn));
  cic_charger_input_config_regs DUT (.*);

  task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : cmp
  task automatic pulse(ref logic s);
    @(negedge clk_sys) s = 1'b1;
    @(negedge clk_sys) s = 1'b0;
    host.tick(2);
  endtask : pulse
  task automatic checkDefaults();
    for (int i = 0; i < 3; i++) begin
      host.rd(i[7:0], q);
      cmp(q, rstTab[i]);
    end
  endtask : checkDefaults
  task automatic results();
    $display("TB counts: %0d bad of %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : results

  // Cuts a hang short; the whole sequence needs well under this.
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      results();
    end
  end

  // Main sequence: register accesses go through the serial link; detection, watchdog and reset are pulsed on pins.
  initial begin
    repeat (5) @(negedge clk_sys);
    srst = 1'b0;
    host.tick(2);
    checkDefaults();
    host.rd(8'h14, q);
    cmp(q, 8'h00);
    host.rd(8'h15, q);
    cmp(q, 8'hFF);
    host.wr(8'h00, 8'hFF);
    cmp(inputHighzEnable, 1'b1);
    cmp(effectiveCurrentCap, 6'h10);
    currentLimitPinCode = 6'h30;
    host.tick(3);
    cmp(effectiveCurrentCap, 6'h30);
    host.wr(8'h00, 8'h3F);
    cmp(effectiveCurrentCap, 6'h3F);
    for (int i = 0; i < 10; i++) begin
      sourceType = i[3:0];
      pulse(detectDone);
      cmp(effectiveCurrentCap, capTab[i]);
      host.rd(8'h00, q);
      cmp(q, {2'b00, capTab[i]});
    end
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h01, {i[1:0], 6'h06});
      cmp(boostHotThresholdSel, i[1:0]);
      cmp(boostHotProtEnable, i != 3);
    end
    host.wr(8'h01, 8'h26);
    cmp(boostColdThresholdSel, 1'b1);
    host.rd(8'h01, q);
    cmp(q, 8'h26);
    for (int i = 0; i < 7; i++) begin
      host.wr(8'h01, {3'b000, ofsTab[i][4:0]});
      supplyNoLoadMv = supTab[i][15:0];
      host.tick(3);
      e = supTab[i] - ofsTab[i] * (supTab[i] > 6000 ? 200 : 100);
      e = e < 3900 ? 3900 : (e > 15300 ? 15300 : e);
      cmp(inputVoltageFloor, e[15:0]);
    end
    host.wr(8'h00, 8'hD2);
    host.wr(8'h01, 8'hE5);
    host.wr(8'h02, 8'h00);
    pulse(watchdogExpire);
    host.rd(8'h00, q);
    cmp(q, 8'h52);
    host.rd(8'h01, q);
    cmp(q, 8'h05);
    pulse(softRegReset);
    checkDefaults();
    cmp(host.missed, 1'b0);
    host.start();
    host.sendByte(8'hA0);
    cmp(host.lastAck, 1'b0);
    host.stop();
    results();
  end
endmodule : cic_charger_input_config_regs_bench

//--- tb/cic_host_model.sv
// Host controller model that masters the two-wire register link.
// Assumes the bank samples both lines on clk_sys and pulls sda via sdaOe.
`timescale 1ns/100ps
module cic_host_model (
  input  wire logic clk_sys,
  input  wire logic sdaOe,
  output logic      sclIn,
  output logic      sdaIn
);
  import cic_pkg::*;
  logic hostLow = 1'b0;
  logic lastAck = 1'b0;
  logic missed  = 1'b0;
  initial sclIn = 1'b1;
  // Pulled-up wire: a released line reads high, either puller wins.
  assign sdaIn = ~(hostLow | sdaOe);

  // Every change lands on a falling edge, away from the sampling edge.
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  // Data moves one cycle after scl falls and is read mid-high.
  task automatic bitSlot(input logic d, output logic q);
    tick(1);
    hostLow = ~d;
    tick(4);
    sclIn = 1'b1;
    tick(2);
    q = sdaIn;
    tick(2);
    sclIn = 1'b0;
  endtask : bitSlot
  task automatic start();
    tick(1);
    hostLow = 1'b0;
    tick(3);
    sclIn = 1'b1;
    tick(4);
    hostLow = 1'b1;
    tick(4);
    sclIn = 1'b0;
  endtask : start
  task automatic stop();
    tick(1);
    hostLow = 1'b1;
    tick(3);
    sclIn = 1'b1;
    tick(4);
    hostLow = 1'b0;
    tick(4);
  endtask : stop
  // Bytes go MSB first; the ninth slot is left free for the acknowledge.
  task automatic sendByte(input logic [7:0] d);
    logic q;
    for (int i = 7; i >= 0; i--) bitSlot(d[i], q);
    bitSlot(1'b1, q);
    lastAck = ~q;
    if (q) missed = 1'b1;
  endtask : sendByte
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    start();
    sendByte({CIC_SLAVE_ADDR, 1'b0});
    sendByte(ptr);
    sendByte(d);
    stop();
  endtask : wr
  // Single read ends with a not-acknowledge so the bank lets go of sda.
  task automatic rd(input logic [7:0] ptr, output logic [7:0] d);
    logic q;
    start();
    sendByte({CIC_SLAVE_ADDR, 1'b0});
    sendByte(ptr);
    start();
    sendByte({CIC_SLAVE_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) bitSlot(1'b1, d[i]);
    bitSlot(1'b1, q);
    stop();
  endtask : rd
endmodule : cic_host_model

//--- tb/cic_regs_sva.sv
// Port assertions for the charger input configuration register bank.
// Assumes it is bound to the bank's top module, one clock domain.
`timescale 1ns/100ps
module cic_regs_sva (
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic       sclIn,
  input wire logic       sdaOe,
  input wire logic       softRegReset,
  input wire logic       watchdogExpire,
  input wire logic       detectDone,
  input wire logic [3:0] sourceType,
  input wire logic [5:0] currentLimitPinCode,
  input wire logic       inputHighzEnable,
  input wire logic       currentPinLimitEnable,
  input wire logic [5:0] effectiveCurrentCap,
  input wire logic [1:0] boostHotThresholdSel,
  input wire logic       boostHotProtEnable,
  input wire logic       boostColdThresholdSel,
  input wire logic [15:0] inputVoltageFloor,
  input wire logic [7:0] conversionDetectControl
);
  import cic_pkg::*;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // Cap code that a finished detection loads for each source type.
  function automatic logic [5:0] capOf(input logic [3:0] t);
    case (t)
      4'h1, 4'h3: capOf = 6'h1C;
      4'h2:       capOf = 6'h3F;
      4'h5:       capOf = 6'h12;
      4'h6:       capOf = 6'h26;
      4'h7:       capOf = 6'h28;
      4'h8:       capOf = 6'h2E;
      default:    capOf = 6'h08;
    endcase
  endfunction : capOf

  property p_floorClamp;
    inputVoltageFloor >= 16'h0F3C && inputVoltageFloor <= 16'h3BC4;
  endproperty
  a_floorClamp: assert property (p_floorClamp)
    else $error("voltage floor outside clamp range");
  property p_capMin;
    currentPinLimitEnable |=>
      effectiveCurrentCap <= $past(currentLimitPinCode);
  endproperty
  a_capMin: assert property (p_capMin)
    else $error("cap above pin limit");
  // Enable and selector are registered together, so no lag is allowed.
  property p_hotProt;
    boostHotProtEnable == (boostHotThresholdSel != 2'b11);
  endproperty
  a_hotProt: assert property (p_hotProt)
    else $error("hot protection enable wrong");
  property p_detect;
    detectDone && !softRegReset && !watchdogExpire |=> ##1
      ($past(currentPinLimitEnable) ||
       effectiveCurrentCap == capOf($past(sourceType, 2)));
  endproperty
  a_detect: assert property (p_detect)
    else $error("detected cap code wrong");
  property p_soft;
    softRegReset |=> conversionDetectControl == 8'h11 && !inputHighzEnable
      && currentPinLimitEnable && boostHotThresholdSel == 2'b00
      && !boostColdThresholdSel;
  endproperty
  a_soft: assert property (p_soft)
    else $error("software reset did not reload");
  property p_wdog;
    watchdogExpire && !softRegReset |=> !inputHighzEnable
      && currentPinLimitEnable && boostHotThresholdSel == 2'b00
      && !boostColdThresholdSel;
  endproperty
  a_wdog: assert property (p_wdog)
    else $error("watchdog did not reload");
  property p_resetVals;
    $fell(srst) |-> !inputHighzEnable && currentPinLimitEnable
      && effectiveCurrentCap == 6'h08 && inputVoltageFloor == 16'h0F3C
      && conversionDetectControl == 8'h11;
  endproperty
  a_resetVals: assert property (p_resetVals)
    else $error("reset values wrong");
  // Data moves only while the serial clock is low.
  property p_sdaEdge;
    $changed(sdaOe) |-> !sclIn;
  endproperty
  a_sdaEdge: assert property (p_sdaEdge)
    else $error("sda changed while scl high");
endmodule : cic_regs_sva

bind cic_charger_input_config_regs cic_regs_sva u_sva (
  .clk_sys                 (clk_sys),
  .srst                    (srst),
  .sclIn                   (sclIn),
  .sdaOe                   (sdaOe),
  .softRegReset            (softRegReset),
  .watchdogExpire          (watchdogExpire),
  .detectDone              (detectDone),
  .sourceType              (sourceType),
  .currentLimitPinCode     (currentLimitPinCode),
  .inputHighzEnable        (inputHighzEnable),
  .currentPinLimitEnable   (currentPinLimitEnable),
  .effectiveCurrentCap     (effectiveCurrentCap),
  .boostHotThresholdSel    (boostHotThresholdSel),
  .boostHotProtEnable      (boostHotProtEnable),
  .boostColdThresholdSel   (boostColdThresholdSel),
  .inputVoltageFloor       (inputVoltageFloor),
  .conversionDetectControl (conversionDetectControl)
);
